// ### pkg/irq_accept_pkg.sv
/*
  constants and types for the two-level interrupt acceptance logic.
  assumes a single system clock domain; nothing here is clocked.
*/
package irq_accept_pkg;
  localparam int NUM_SOURCES  = 16;
  localparam int VEC_W        = 8;
  localparam int ADDR_W       = 16;
  localparam int VEC_STRIDE   = 2;
  localparam int NMI_SRC      = 0;
  localparam int ABRK_SRC     = 1;
  localparam logic [15:0] VEC_BASE_RST = 16'h0000;
  localparam logic [15:0] LEVEL_RST    = 16'h0000;
  localparam logic        MASK_RST     = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_INSN,
    ST_PUSH_PC,
    ST_PUSH_CCR,
    ST_SET_MASK,
    ST_FETCH_VEC,
    ST_JUMP
  } accept_state_t;
endpackage

// ### design/vector_rom.sv
/*
  small handler-address table indexed by source number, registered read.
  assumes the table is loaded by the core through the write port before use.
*/
`timescale 1ns/1ns
module vector_rom #(
  parameter int DEPTH  = 16,
  parameter int AW     = 4,
  parameter int DW     = 16
) (
  // clocking
  input  wire logic          clk,
  input  wire logic          ce,
  // write port
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // read port
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);
  logic [DW-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin
      $error("DEPTH must be reachable with AW address bits");
    end
  end

  always_ff @(posedge clk) begin
    if (ce && wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

// ### design/two_level_interrupt_acceptance.sv
/*
  interrupt acceptance for the simple two-level control scheme: source
  latching, level/priority selection, mask check and the exception sequence.
  assumes the core signals instruction completion with insnDone and takes
  the stack pushes and jump target from the strobed outputs below.
*/
// How it works
// - maskable requests are enabled while the core mask bit is 0 and blocked while it is 1.
// - a source becomes pending only if its event occurs while its enable bit is 1.
// - a pending source at control level 1 is selected before any level 0 source, which stays pending.
// - among same-level pending sources the highest fixed-priority one wins.
// - with the mask bit at 1 only the non-maskable and address-break requests can be accepted.
// - exception processing starts only after the current instruction has completed.
// - the resume address and the condition code register are pushed onto the stack.
// - after the pushes the mask bit is set to 1.
// - a vector address is formed, the handler address read from it, and execution jumps there.
`timescale 1ns/1ns
module two_level_interrupt_acceptance #(
  parameter int NSRC = irq_accept_pkg::NUM_SOURCES
) (
  // clocking
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // sources
  input  wire logic [NSRC-1:0]          srcEvent,
  input  wire logic [NSRC-1:0]          srcEnable,
  input  wire logic [NSRC-1:0]          irqLevelSelectReg,
  // core state
  input  wire logic                     insnDone,
  input  wire logic [15:0]              resumePc,
  input  wire logic [7:0]               conditionCodeReg,
  input  wire logic                     maskWrEn,
  input  wire logic                     maskWrData,
  // vector table load
  input  wire logic                     vecWrEn,
  input  wire logic [$clog2(NSRC)-1:0]  vecWrIdx,
  input  wire logic [15:0]              vecWrData,
  // to core
  output logic                          globalMask,
  output logic                          acceptBusy,
  output logic                          pushPcStrobe,
  output logic [15:0]                   pushPc,
  output logic                          pushCcrStrobe,
  output logic [7:0]                    pushCcr,
  output logic [irq_accept_pkg::VEC_W-1:0] acceptVector,
  output logic [15:0]                   vectorAddr,
  output logic                          jumpStrobe,
  output logic [15:0]                   jumpTarget,
  output logic [NSRC-1:0]               pendingOut
);
  localparam int IW = $clog2(NSRC);

  initial begin
    if (NSRC < 2 || NSRC > 256) begin
      $error("NSRC must be between 2 and 256");
    end
  end

  irq_accept_pkg::accept_state_t state;
  logic [NSRC-1:0] pending;
  logic [IW-1:0]   selIdx;
  logic [IW-1:0]   takenIdx;
  logic            selValid;
  logic [15:0]     handlerAddr;

  // lowest set bit wins: the constant ranking is the index itself
  function automatic logic [IW:0] pick_first(input logic [NSRC-1:0] req);
    logic [IW:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  logic [NSRC-1:0] unmaskable;
  logic [NSRC-1:0] eligible;
  logic [IW:0]     pickHi;
  logic [IW:0]     pickLo;

  always_comb begin
    unmaskable = '0;
    unmaskable[irq_accept_pkg::NMI_SRC]  = 1'b1;
    unmaskable[irq_accept_pkg::ABRK_SRC] = 1'b1;
    eligible = globalMask ? (pending & unmaskable) : pending;
    pickHi   = pick_first(eligible & irqLevelSelectReg);
    pickLo   = pick_first(eligible & ~irqLevelSelectReg);
    selValid = pickHi[IW] | pickLo[IW];
    selIdx   = pickHi[IW] ? pickHi[IW-1:0] : pickLo[IW-1:0];
  end

  // pending latches; a new event wins over the clear on acceptance
  always_ff @(posedge clk) begin
    if (rst) begin
      pending <= '0;
    end else if (ce) begin
      for (int i = 0; i < NSRC; i++) begin
        if (srcEvent[i] && srcEnable[i]) begin
          pending[i] <= 1'b1;
        end else if (state == irq_accept_pkg::ST_WAIT_INSN && insnDone && takenIdx == IW'(i)) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= irq_accept_pkg::ST_IDLE;
      takenIdx <= '0;
    end else if (ce) begin
      unique case (state)
        irq_accept_pkg::ST_IDLE: begin
          if (selValid) begin
            takenIdx <= selIdx;
            state    <= irq_accept_pkg::ST_WAIT_INSN;
          end
        end
        irq_accept_pkg::ST_WAIT_INSN: begin
          if (insnDone) begin
            state <= irq_accept_pkg::ST_PUSH_PC;
          end
        end
        irq_accept_pkg::ST_PUSH_PC:   state <= irq_accept_pkg::ST_PUSH_CCR;
        irq_accept_pkg::ST_PUSH_CCR:  state <= irq_accept_pkg::ST_SET_MASK;
        irq_accept_pkg::ST_SET_MASK:  state <= irq_accept_pkg::ST_FETCH_VEC;
        irq_accept_pkg::ST_FETCH_VEC: state <= irq_accept_pkg::ST_JUMP;
        irq_accept_pkg::ST_JUMP:      state <= irq_accept_pkg::ST_IDLE;
        // the eighth code of the 3-bit state is unused; recover to idle rather than lock up
        default:                      state <= irq_accept_pkg::ST_IDLE;
      endcase
    end
  end

  // resume address captured at completion so the push shows the next instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      pushPcStrobe  <= 1'b0;
      pushPc        <= '0;
      pushCcrStrobe <= 1'b0;
      pushCcr       <= '0;
    end else if (ce) begin
      pushPcStrobe  <= (state == irq_accept_pkg::ST_PUSH_PC);
      pushCcrStrobe <= (state == irq_accept_pkg::ST_PUSH_CCR);
      if (state == irq_accept_pkg::ST_WAIT_INSN && insnDone) begin
        pushPc  <= resumePc;
        pushCcr <= conditionCodeReg;
      end
    end
  end

  // the mask is owned here so the set after stacking cannot race the core
  always_ff @(posedge clk) begin
    if (rst) begin
      globalMask <= irq_accept_pkg::MASK_RST;
    end else if (ce) begin
      if (state == irq_accept_pkg::ST_SET_MASK) begin
        globalMask <= 1'b1;
      end else if (maskWrEn) begin
        globalMask <= maskWrData;
      end
    end
  end

  vector_rom #(
    .DEPTH (NSRC),
    .AW    (IW),
    .DW    (16)
  ) u_vectors (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (vecWrEn),
    .wrAddr (vecWrIdx),
    .wrData (vecWrData),
    .rdAddr (takenIdx),
    .rdData (handlerAddr)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      acceptVector <= '0;
      vectorAddr   <= '0;
      jumpStrobe   <= 1'b0;
      jumpTarget   <= '0;
    end else if (ce) begin
      jumpStrobe <= (state == irq_accept_pkg::ST_JUMP);
      if (state == irq_accept_pkg::ST_SET_MASK) begin
        acceptVector <= irq_accept_pkg::VEC_W'(takenIdx);
        vectorAddr   <= 16'(irq_accept_pkg::VEC_BASE_RST + 16'(takenIdx) * 16'(irq_accept_pkg::VEC_STRIDE));
      end
      if (state == irq_accept_pkg::ST_JUMP) begin
        jumpTarget <= handlerAddr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acceptBusy <= 1'b0;
      pendingOut <= '0;
    end else if (ce) begin
      acceptBusy <= (state != irq_accept_pkg::ST_IDLE);
      pendingOut <= pending;
    end
  end
endmodule

// ### dv/two_level_interrupt_acceptance_sva.sv
/* timing and value checks on the acceptance ports.
   assumes one clock domain and a sync active-high reset. */
`timescale 1ns/1ns
module two_level_interrupt_acceptance_sva #(parameter int NSRC = irq_accept_pkg::NUM_SOURCES) (
  // clocking and core side
  input wire logic clk, rst, ce, insnDone, globalMask,
  input wire logic [15:0] resumePc, pushPc, vectorAddr,
  input wire logic [7:0] conditionCodeReg, pushCcr,
  // strobes and sources
  input wire logic pushPcStrobe, pushCcrStrobe, jumpStrobe,
  input wire logic [NSRC-1:0] srcEvent, srcEnable, pendingOut,
  input wire logic [irq_accept_pkg::VEC_W-1:0] acceptVector
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [NSRC-1:0] hit;
  assign hit = srcEvent & srcEnable;
  sequence s_push;
    pushPcStrobe ##1 pushCcrStrobe;
  endsequence
  a_ccr_after_pc: assert property (pushPcStrobe |-> s_push) else $error("ccr push missing");
  a_pc_value: assert property (pushPcStrobe |-> pushPc == resumePc) else $error("pushed pc wrong");
  a_ccr_value: assert property (pushCcrStrobe |-> pushCcr == conditionCodeReg) else $error("pushed ccr wrong");
  a_mask_set: assert property (s_push |=> globalMask) else $error("mask not set");
  a_jump_timing: assert property (s_push |-> ##3 jumpStrobe) else $error("jump late");
  a_vec_form: assert property (jumpStrobe |-> vectorAddr ==
    irq_accept_pkg::VEC_BASE_RST + 16'(acceptVector * irq_accept_pkg::VEC_STRIDE)) else $error("vector addr");
  a_insn_wait: assert property (pushPcStrobe |-> $past(insnDone, 2)) else $error("no insn done");
  // a low clock enable freezes the latches, so only events seen with the block running must show up
  a_pend_latch: assert property ((ce && hit != 0) ##1 ce |=> (pendingOut & $past(hit, 2)) == $past(hit, 2))
    else $error("event lost");
endmodule
bind two_level_interrupt_acceptance two_level_interrupt_acceptance_sva #(.NSRC(NSRC)) u_sva (.clk, .rst, .ce,
  .insnDone, .globalMask, .resumePc, .pushPc, .vectorAddr, .conditionCodeReg, .pushCcr, .pushPcStrobe,
  .pushCcrStrobe, .jumpStrobe, .srcEvent, .srcEnable, .pendingOut, .acceptVector);

// ### dv/core_model.sv
/* core stand-in: completes instructions at a random pace.
   assumes acceptBusy covers the whole exception sequence. */
`timescale 1ns/1ns
module core_model (
  // clocking
  input wire logic clk,
  input wire logic rst,
  // from acceptance logic
  input wire logic acceptBusy,
  // to acceptance logic
  output logic insnDone,
  output logic [15:0] resumePc,
  output logic [7:0] conditionCodeReg
);
  int gap = 0;
  // long instructions make the acceptance wait for completion
  always @(negedge clk) begin
    insnDone <= !rst && gap == 0;
    gap <= (rst || gap == 0) ? $urandom_range(5) : gap - 1;
    // state only moves while no sequence is saving it
    if (!acceptBusy) begin
      resumePc <= 16'($urandom);
      conditionCodeReg <= 8'($urandom);
    end
  end
endmodule

// ### dv/test_two_level_interrupt_acceptance.sv
/* self-checking bench: masking, priority order and handler jumps.
   assumes core_model drives the core state inputs. */
`timescale 1ns/1ns
module test_two_level_interrupt_acceptance;
  logic clk = 0, rst = 1, ce = 1, maskWrEn = 0, maskWrData = 0, vecWrEn = 0;
  logic [15:0] srcEvent = 0, srcEnable = 0, irqLevelSelectReg = 0, vecWrData = 0;
  logic [15:0] pushPc, jumpTarget, vectorAddr, pendingOut, resumePc, s, l;
  logic [3:0] vecWrIdx = 0;
  logic [7:0] acceptVector, pushCcr, conditionCodeReg;
  logic insnDone, globalMask, acceptBusy, pushPcStrobe, pushCcrStrobe, jumpStrobe;
  logic mk;
  logic [15:0] tbl [16];
  int fails = 0, check_count = 0, i, w;
  always #2 clk = ~clk;
  two_level_interrupt_acceptance u_dut (.clk, .rst, .ce, .srcEvent, .srcEnable, .irqLevelSelectReg,
    .insnDone, .resumePc, .conditionCodeReg, .maskWrEn, .maskWrData, .vecWrEn, .vecWrIdx, .vecWrData,
    .globalMask, .acceptBusy, .pushPcStrobe, .pushPc, .pushCcrStrobe, .pushCcr, .acceptVector,
    .vectorAddr, .jumpStrobe, .jumpTarget, .pendingOut);
  core_model u_core (.clk, .rst, .acceptBusy, .insnDone, .resumePc, .conditionCodeReg);
  task chk(string n, logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task fire(logic [15:0] ev, en);
    srcEvent = ev;
    srcEnable = en;
    cyc(1);
    srcEvent = 0;
  endtask
  task unmask;
    maskWrEn = 1;
    cyc(1);
    maskWrEn = 0;
  endtask
  task take(int e);
    for (w = 0; w < 200 && jumpStrobe !== 1'b1; w++) cyc(1);
    chk("jump", 1, jumpStrobe);
    chk("vector", 16'(e), acceptVector);
    chk("target", tbl[e], jumpTarget);
    chk("vaddr", 16'(irq_accept_pkg::VEC_BASE_RST + e * irq_accept_pkg::VEC_STRIDE), vectorAddr);
    cyc(1);
  endtask
  // level 1 first, then lowest index
  function int win(logic [15:0] a, b);
    for (int k = 0; k < 16; k++) if (a[k] & b[k]) return k;
    for (int k = 0; k < 16; k++) if (a[k]) return k;
    return 0;
  endfunction
  task finish_test;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    finish_test;
  end
  initial begin
    void'($urandom(52767));
    cyc(5);
    rst = 0;
    chk("mask", 1, globalMask);
    chk("pend", 0, pendingOut);
    for (i = 0; i < 16; i++) begin
      tbl[i] = 16'($urandom);
      vecWrEn = 1;
      vecWrIdx = 4'(i);
      vecWrData = tbl[i];
      cyc(1);
    end
    vecWrEn = 0;
    // an event while the block is frozen must leave no trace
    ce = 0;
    fire(16'h0004, 16'h0004);
    cyc(2);
    chk("frozen", 0, pendingOut);
    ce = 1;
    fire(16'h0060, 16'h0020);
    cyc(20);
    chk("held", 16'h0020, pendingOut);
    chk("busy", 0, acceptBusy);
    fire(16'h0001, 16'h0001);
    take(0);
    unmask;
    take(5);
    chk("mask", 1, globalMask);
    repeat (20) begin
      s = 16'($urandom);
      l = 16'($urandom);
      irqLevelSelectReg = l;
      unmask;
      fire(s, s);
      mk = 0;
      // after each jump the mask is still set for two idle edges, so only sources 0 and 1 can go first
      while (s != 0) begin
        i = win((mk && (s & 16'h0003) != 0) ? (s & 16'h0003) : s, l);
        take(i);
        s[i] = 0;
        mk = 1;
        unmask;
      end
    end
    finish_test;
  end
endmodule
